//--- hw/status_output_terminal_selector.sv
// Three-terminal status output selector with APB registers and interrupt
//
// Our own choices: the placing of the registers and the APB interface to the registers.
module status_output_terminal_selector
    import out_sel_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire drive_flags_s flags,
    input wire drive_meas_s meas,
    output logic relay_out,
    output logic digital_out_one,
    output logic digital_out_two,
    output logic irq
);
    // Percent reduction: value - value*pct/100
    function automatic logic [15:0] off_level(input logic [15:0] v, input logic [6:0] pct);
        logic [22:0] prod;
        prod = v * pct;
        return v - 16'(prod / 23'd100);
    endfunction

    // Absolute difference
    function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
        return (a > b) ? (a - b) : (b - a);
    endfunction

    // Two-flop synchroniser for pin-side flags and measurements
    drive_flags_s flags_s1_reg, flags_reg;
    drive_meas_s meas_s1_reg, meas_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_s1_reg <= '0;
            flags_reg <= '0;
            meas_s1_reg <= '0;
            meas_reg <= '0;
        end else begin
            flags_s1_reg <= flags;
            flags_reg <= flags_s1_reg;
            meas_s1_reg <= meas;
            meas_reg <= meas_s1_reg;
        end
    end

    // Configuration registers
    logic [5:0] sel_reg [N_TERM];               // Selector per terminal
    logic [15:0] freq_one_reg, freq_two_reg;    // Characteristic frequencies
    logic [6:0] freq_width_reg;                 // Frequency width percent
    logic [15:0] curr_reg;                      // Characteristic current
    logic [6:0] curr_width_reg;                 // Current width percent
    logic [15:0] arrival_reg;                   // Arrival threshold
    logic [2:0] int_stat_reg, int_mask_reg;     // Interrupt status and mask

    // APB decode
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire hit_sel0 = (paddr == OFS_RELAY_SEL);
    wire hit_sel1 = (paddr == OFS_DOUT1_SEL);
    wire hit_sel2 = (paddr == OFS_DOUT2_SEL);
    wire hit_f1 = (paddr == OFS_FREQ_ONE);
    wire hit_f2 = (paddr == OFS_FREQ_TWO);
    wire hit_fw = (paddr == OFS_FREQ_WIDTH);
    wire hit_c = (paddr == OFS_CURR);
    wire hit_cw = (paddr == OFS_CURR_WIDTH);
    wire hit_ar = (paddr == OFS_ARRIVAL);
    wire hit_st = (paddr == OFS_STATUS);
    wire hit_is = (paddr == OFS_INT_STAT);
    wire hit_im = (paddr == OFS_INT_MASK);
    wire mapped = hit_sel0 | hit_sel1 | hit_sel2 | hit_f1 | hit_f2 | hit_fw | hit_c | hit_cw
                  | hit_ar | hit_st | hit_is | hit_im;
    // Out-of-range selector or percent write is refused with an error
    wire sel_bad = (hit_sel0 | hit_sel1 | hit_sel2) && (pwdata[5:0] > SEL_MAX || pwdata[31:6] != '0);
    wire pct_bad = (hit_fw | hit_cw) && (pwdata[6:0] > PCT_MAX || pwdata[31:7] != '0);
    wire wr_err = wr && (sel_bad || pct_bad || hit_st);
    wire wr_ok = wr && mapped && !wr_err;
    wire rd_err = acc && !pwrite && !mapped;
    wire [5:0] wsel = pwdata[5:0];
    wire [15:0] wval = pwdata[15:0];
    wire [6:0] wpct = pwdata[6:0];

    // Selector registers with documented defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg[0] <= RELAY_RST;
            sel_reg[1] <= DOUT1_RST;
            sel_reg[2] <= DOUT2_RST;
        end else if (wr_ok) begin
            if (hit_sel0) sel_reg[0] <= wsel;
            if (hit_sel1) sel_reg[1] <= wsel;
            if (hit_sel2) sel_reg[2] <= wsel;
        end
    end

    // Threshold registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_one_reg <= FREQ_ONE_RST;
            freq_two_reg <= FREQ_TWO_RST;
            freq_width_reg <= FREQ_WIDTH_RST;
            curr_reg <= CURR_RST;
            curr_width_reg <= CURR_WIDTH_RST;
            arrival_reg <= ARRIVAL_RST;
        end else if (wr_ok) begin
            if (hit_f1) freq_one_reg <= wval;
            if (hit_f2) freq_two_reg <= wval;
            if (hit_fw) freq_width_reg <= wpct;
            if (hit_c) curr_reg <= wval;
            if (hit_cw) curr_width_reg <= wpct;
            if (hit_ar) arrival_reg <= wval;
        end
    end

    // Hysteresis comparators for characteristic frequency and current
    logic f1_on_reg, f2_on_reg, cur_on_reg;
    wire [15:0] fq = meas_reg.out_freq;
    wire [15:0] cu = meas_reg.out_curr;
    wire f1_next = (fq > freq_one_reg) ? 1'b1 : (fq < off_level(freq_one_reg, freq_width_reg)) ? 1'b0 : f1_on_reg;
    wire f2_next = (fq > freq_two_reg) ? 1'b1 : (fq < off_level(freq_two_reg, freq_width_reg)) ? 1'b0 : f2_on_reg;
    wire cur_next = (cu >= curr_reg) ? 1'b1 : (cu < off_level(curr_reg, curr_width_reg)) ? 1'b0 : cur_on_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            f1_on_reg <= 1'b0;
            f2_on_reg <= 1'b0;
            cur_on_reg <= 1'b0;
        end else begin
            f1_on_reg <= f1_next;
            f2_on_reg <= f2_next;
            cur_on_reg <= cur_next;
        end
    end

    // Coast-stop latch: set by stop in coast mode, held until output stops
    logic coast_reg;
    wire coast_next = (flags_reg.coast_mode && flags_reg.stop_cmd && flags_reg.running)
                      || (coast_reg && flags_reg.running);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) coast_reg <= 1'b0;
        else coast_reg <= coast_next;
    end

    // Overload pre-alarm: on at half time, off when overload ends or trips
    wire drv_pre = flags_reg.drv_ovl && flags_reg.drv_ovl_half && !flags_reg.drv_ovl_trip;
    wire mot_pre = flags_reg.mot_ovl && flags_reg.mot_ovl_half && !flags_reg.mot_ovl_trip;
    // Overheat pre-alarm: on at 80 percent, off on trip or below level
    wire heat_pre = flags_reg.temp_80 && !flags_reg.heat_trip;
    // Ready: powered, no protection, ready
    wire rdy = flags_reg.powered && !flags_reg.protect_act && flags_reg.ready;
    // At speed: running and within arrival threshold of target
    wire at_spd = flags_reg.running
                  && (abs_diff(meas_reg.out_freq, meas_reg.target_freq) <= arrival_reg);

    // Selection mux; speed search flag is not a term, so routing runs through it
    function automatic logic route(input logic [5:0] code);
        logic r;
        r = 1'b0;
        case (code)
            C_NONE: r = 1'b0;
            C_FAULT: r = flags_reg.fault;
            C_FREQ1: r = f1_on_reg;
            C_FREQ2: r = f2_on_reg;
            C_COAST: r = coast_reg;
            C_RUN1: r = flags_reg.running;
            C_DCB: r = flags_reg.dc_braking;
            C_ALT_RAMP: r = flags_reg.alt_ramp;
            C_CNT_SET: r = flags_reg.cnt_set_hit;
            C_CNT_DES: r = flags_reg.cnt_des_hit;
            C_DRV_OVL: r = drv_pre;
            C_MOT_OVL: r = mot_pre;
            C_STALL: r = flags_reg.stall_hold;
            C_READY: r = rdy;
            C_RUN2: r = flags_reg.running;             // Zero hertz still counts
            C_AT_SPEED: r = at_spd;
            C_OVERHEAT: r = heat_pre;
            C_CURR: r = cur_on_reg;
            default: r = 1'b0;                         // Reserved codes idle
        endcase
        return r;
    endfunction

    // Terminal drive; no gating by speed search
    wire [2:0] term_next = {route(sel_reg[2]), route(sel_reg[1]), route(sel_reg[0])};
    logic [2:0] term_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) term_reg <= '0;
        else term_reg <= term_next;
    end
    assign relay_out = term_reg[0];
    assign digital_out_one = term_reg[1];
    assign digital_out_two = term_reg[2];

    // Interrupt: sticky edge events, write one to clear, set wins
    wire [2:0] ev = term_next ^ term_reg;
    wire [2:0] w1c = (wr_ok && hit_is) ? pwdata[2:0] : 3'h0;
    wire [2:0] int_next = ev | (int_stat_reg & ~w1c);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_reg <= INT_RST;
            int_mask_reg <= INT_RST;
            irq <= 1'b0;
        end else begin
            int_stat_reg <= int_next;
            if (wr_ok && hit_im) int_mask_reg <= pwdata[2:0];
            irq <= |(int_next & int_mask_reg);
        end
    end

    // Read mux
    wire [31:0] status_word = {16'h0000, 5'h00, heat_pre, rdy, flags_reg.speed_search,
                               coast_reg, cur_on_reg, f2_on_reg, f1_on_reg, 1'b0, term_reg};
    wire [31:0] rd_word =
        hit_sel0 ? {26'h0, sel_reg[0]} :
        hit_sel1 ? {26'h0, sel_reg[1]} :
        hit_sel2 ? {26'h0, sel_reg[2]} :
        hit_f1 ? {16'h0, freq_one_reg} :
        hit_f2 ? {16'h0, freq_two_reg} :
        hit_fw ? {25'h0, freq_width_reg} :
        hit_c ? {16'h0, curr_reg} :
        hit_cw ? {25'h0, curr_width_reg} :
        hit_ar ? {16'h0, arrival_reg} :
        hit_st ? status_word :
        hit_is ? {29'h0, int_stat_reg} :
        hit_im ? {29'h0, int_mask_reg} : 32'h0000_0000;

    // APB answer: registered, no wait state, pready one cycle in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            prdata <= (psel && !penable && !pwrite) ? rd_word : prdata;
            pslverr <= psel && !penable && (!mapped || (pwrite && (sel_bad || pct_bad || hit_st)));
        end
    end

    // Assertions
    a_zero_code_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg[0] == C_NONE) |=> !relay_out)
        else $error("relay active with code 0");
    a_fault_route: assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg[0] == C_FAULT && $stable(sel_reg[0])) |=> (relay_out == $past(flags_reg.fault)))
        else $error("fault not routed");
    a_run_route: assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg[2] == C_RUN1 && flags_reg.running) |=> digital_out_two)
        else $error("run not routed");
    a_reserved_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg[2] > C_CURR) |=> !digital_out_two)
        else $error("reserved code drove output");
    a_coast_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (coast_reg && flags_reg.running) |=> coast_reg)
        else $error("coast flag dropped while running");
    a_freq_hyst: assert property (@(posedge pclk) disable iff (!presetn)
        (f1_on_reg && fq >= off_level(freq_one_reg, freq_width_reg)) |=> f1_on_reg)
        else $error("frequency flag dropped in band");
    a_ovl_trip_off: assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg[0] == C_DRV_OVL && $stable(sel_reg[0]) && flags_reg.drv_ovl_trip) |=> !relay_out)
        else $error("pre-alarm held after trip");
    a_heat_trip_off: assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg[2] == C_OVERHEAT && $stable(sel_reg[2]) && flags_reg.heat_trip) |=> !digital_out_two)
        else $error("overheat held after trip");
    a_sel_range: assert property (@(posedge pclk) disable iff (!presetn)
        sel_reg[0] <= SEL_MAX && sel_reg[1] <= SEL_MAX && sel_reg[2] <= SEL_MAX)
        else $error("selector out of range");
endmodule // status_output_terminal_selector

//--- shared/out_sel_pkg.sv
// Constants, types and register map for the status output terminal selector
// Summary of operation
// - Three selectors, range 0..42, defaults 1,14,5
// - Selection keeps working during speed search
// - Code 0 leaves terminal inactive
// - Code 1 asserts on fault trip
// - Code 4 holds from coast stop until stopped
// - Code 5 asserts while running
// - Code 14 running, zero hertz counts too
// - Code 6 asserts during DC braking
// - Code 7 asserts on alternate ramp set
// - Codes 8/9 assert on count reached
// - Codes 10/11 half-time overload pre-alarm
// - Code 12 asserts while stall holds ramp
// - Code 13 powered, unprotected, ready to run
// - Code 15 asserts at target within threshold
// - Code 16 overheat pre-alarm at 80 percent
// - Code 17 asserts at characteristic current
// - Frequency codes on above, off below width
package out_sel_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_RELAY_SEL = 12'h000;
    localparam logic [11:0] OFS_DOUT1_SEL = 12'h004;
    localparam logic [11:0] OFS_DOUT2_SEL = 12'h008;
    localparam logic [11:0] OFS_FREQ_ONE = 12'h00C;
    localparam logic [11:0] OFS_FREQ_TWO = 12'h010;
    localparam logic [11:0] OFS_FREQ_WIDTH = 12'h014;
    localparam logic [11:0] OFS_CURR = 12'h018;
    localparam logic [11:0] OFS_CURR_WIDTH = 12'h01C;
    localparam logic [11:0] OFS_ARRIVAL = 12'h020;
    localparam logic [11:0] OFS_STATUS = 12'h024;
    localparam logic [11:0] OFS_INT_STAT = 12'h028;
    localparam logic [11:0] OFS_INT_MASK = 12'h02C;
    // Selector field
    localparam int SEL_W = 6;
    localparam logic [5:0] SEL_MAX = 6'h2A;
    localparam logic [5:0] RELAY_RST = 6'h01;
    localparam logic [5:0] DOUT1_RST = 6'h0E;
    localparam logic [5:0] DOUT2_RST = 6'h05;
    // Numeric fields: frequency in 0.01 Hz, current in 0.1 A, width in percent
    localparam int VAL_W = 16;
    localparam logic [15:0] FREQ_ONE_RST = 16'h03E8;
    localparam logic [15:0] FREQ_TWO_RST = 16'h1388;
    localparam logic [6:0] FREQ_WIDTH_RST = 7'h32;
    localparam logic [15:0] CURR_RST = 16'h0064;
    localparam logic [6:0] CURR_WIDTH_RST = 7'h0A;
    localparam logic [15:0] ARRIVAL_RST = 16'h0000;
    localparam logic [6:0] PCT_MAX = 7'h64;
    // Selector codes
    localparam logic [5:0] C_NONE = 6'h00;
    localparam logic [5:0] C_FAULT = 6'h01;
    localparam logic [5:0] C_FREQ1 = 6'h02;
    localparam logic [5:0] C_FREQ2 = 6'h03;
    localparam logic [5:0] C_COAST = 6'h04;
    localparam logic [5:0] C_RUN1 = 6'h05;
    localparam logic [5:0] C_DCB = 6'h06;
    localparam logic [5:0] C_ALT_RAMP = 6'h07;
    localparam logic [5:0] C_CNT_SET = 6'h08;
    localparam logic [5:0] C_CNT_DES = 6'h09;
    localparam logic [5:0] C_DRV_OVL = 6'h0A;
    localparam logic [5:0] C_MOT_OVL = 6'h0B;
    localparam logic [5:0] C_STALL = 6'h0C;
    localparam logic [5:0] C_READY = 6'h0D;
    localparam logic [5:0] C_RUN2 = 6'h0E;
    localparam logic [5:0] C_AT_SPEED = 6'h0F;
    localparam logic [5:0] C_OVERHEAT = 6'h10;
    localparam logic [5:0] C_CURR = 6'h11;
    // Interrupt bits: one per terminal, set on any change of its level
    localparam int N_TERM = 3;
    localparam logic [2:0] INT_RST = 3'h0;
    // Drive status flags from the controller (pin side)
    typedef struct packed {
        logic fault;          // Drive tripped
        logic coast_mode;     // Stop mode is coast
        logic stop_cmd;       // Stop command present
        logic running;        // Running state
        logic dc_braking;     // DC braking active
        logic alt_ramp;       // Alternate ramp set selected
        logic cnt_set_hit;    // Counter reached set value
        logic cnt_des_hit;    // Counter reached designated value
        logic drv_ovl;        // Drive overload present
        logic drv_ovl_half;   // Half protection time elapsed
        logic drv_ovl_trip;   // Drive overload protection tripped
        logic mot_ovl;        // Motor overload present
        logic mot_ovl_half;   // Motor half time elapsed
        logic mot_ovl_trip;   // Motor overload protection tripped
        logic stall_hold;     // Ramp held by stall prevention
        logic powered;        // Supply healthy
        logic protect_act;    // Protection function active
        logic ready;          // Ready to run
        logic temp_80;        // Temperature at 80 percent
        logic heat_trip;      // Overheat protection tripped
        logic speed_search;   // Flying start in progress
    } drive_flags_s;
    localparam int FLAG_W = $bits(drive_flags_s);
    typedef struct packed {
        logic [15:0] out_freq;     // Output frequency
        logic [15:0] target_freq;  // Target frequency
        logic [15:0] out_curr;     // Output current
    } drive_meas_s;
endpackage : out_sel_pkg

//--- tb/status_output_terminal_selector_bench.sv
// Self-checking bench for the status output terminal selector
module status_output_terminal_selector_bench import out_sel_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // One pending expectation of an APB transfer
    typedef struct {
        logic [31:0] data; // Expected read data
        logic [31:0] mask; // Bits compared
        logic err; // Expected error response
        logic pins; // Terminal pins compared too
        logic irq; // Expected interrupt level
    } note_s;
    note_s notes[$]; // Pending expectations
    note_s cur; // Expectation under comparison
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    drive_flags_s flags;
    drive_meas_s meas;
    logic relay_out;
    logic digital_out_one;
    logic digital_out_two;
    logic irq;
    logic [2:0] seen; // Levels as the load sees them
    logic exp_irq; // Interrupt level expected now
    logic [5:0] rc; // Random reserved code
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;
    status_output_terminal_selector dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flags(flags), .meas(meas), .relay_out(relay_out), .digital_out_one(digital_out_one),
        .digital_out_two(digital_out_two), .irq(irq));
    term_load_model load_u (.pclk(pclk), .presetn(presetn), .relay_out(relay_out),
        .digital_out_one(digital_out_one), .digital_out_two(digital_out_two), .seen(seen));
    // Clock of 50 ns
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Counts and reports one comparison
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Closing report
    task automatic print_verdict();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // One APB transfer; a read passes its expected data in d
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic e, input logic p);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        notes.push_back('{data: d, mask: w ? 32'h0 : m, err: e, pins: p, irq: exp_irq});
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d, 32'h0, e, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
        apb(1'b0, a, d, m, 1'b0, 1'b0);
    endtask
    // Route a code to relay and second output, apply flags, expect both levels
    task automatic tc(input logic [5:0] c, input drive_flags_s f, input logic e);
        wr(OFS_RELAY_SEL, {26'h0, c}, 1'b0);
        wr(OFS_DOUT2_SEL, {26'h0, c}, 1'b0);
        flags <= f;
        repeat (6) @(posedge pclk);
        apb(1'b0, OFS_STATUS, {29'h0, e, 1'b0, e}, 32'h7, 1'b0, 1'b1);
    endtask
    task automatic ms(input logic [15:0] fo, input logic [15:0] ft, input logic [15:0] cu);
        meas <= '{out_freq: fo, target_freq: ft, out_curr: cu};
    endtask
    // Monitor: oldest expectation against each answered transfer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
            cur = notes.pop_front();
            check(prdata & cur.mask, cur.data & cur.mask);
            check({31'h0, pslverr}, {31'h0, cur.err});
            check({31'h0, irq}, {31'h0, cur.irq});
            if (cur.pins) begin
                check({29'h0, seen}, cur.data & 32'h7);
            end
        end
    end
    // Hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end
    // Main sequence
    initial begin
        void'($urandom(32'hAD3F));
        {psel, penable, pwrite, paddr, pwdata} = '0;
        flags = '0;
        meas = '0;
        exp_irq = 1'b0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_RELAY_SEL, 32'h1, 32'hFFFFFFFF);
        rd(OFS_DOUT1_SEL, 32'hE, 32'hFFFFFFFF);
        rd(OFS_DOUT2_SEL, 32'h5, 32'hFFFFFFFF);
        wr(OFS_RELAY_SEL, 32'h2B, 1'b1);
        rd(OFS_RELAY_SEL, 32'h1, 32'hFFFFFFFF);
        wr(OFS_RELAY_SEL, 32'h2A, 1'b0);
        rd(OFS_RELAY_SEL, 32'h2A, 32'hFFFFFFFF);
        wr(OFS_STATUS, 32'h0, 1'b1);
        apb(1'b0, 12'h030, 32'h0, 32'hFFFFFFFF, 1'b1, 1'b0);
        wr(OFS_DOUT1_SEL, 32'h0, 1'b0);
        tc(C_NONE, '1, 1'b0);
        tc(C_FAULT, '{fault: 1'b1, speed_search: 1'b1, default: 1'b0}, 1'b1);
        tc(C_FAULT, '{fault: 1'b0, default: 1'b1}, 1'b0);
        tc(C_RUN1, '{running: 1'b1, default: 1'b0}, 1'b1);
        tc(C_RUN1, '{running: 1'b0, default: 1'b1}, 1'b0);
        tc(C_RUN2, '{running: 1'b1, default: 1'b0}, 1'b1);
        tc(C_DCB, '{dc_braking: 1'b1, default: 1'b0}, 1'b1);
        tc(C_ALT_RAMP, '{alt_ramp: 1'b1, default: 1'b0}, 1'b1);
        tc(C_CNT_SET, '{cnt_set_hit: 1'b1, default: 1'b0}, 1'b1);
        tc(C_CNT_SET, '{cnt_des_hit: 1'b1, default: 1'b0}, 1'b0);
        tc(C_CNT_DES, '{cnt_des_hit: 1'b1, default: 1'b0}, 1'b1);
        tc(C_DRV_OVL, '{drv_ovl: 1'b1, drv_ovl_half: 1'b1, default: 1'b0}, 1'b1);
        tc(C_DRV_OVL, '{drv_ovl: 1'b1, default: 1'b0}, 1'b0);
        tc(C_DRV_OVL, '{drv_ovl: 1'b1, drv_ovl_half: 1'b1, drv_ovl_trip: 1'b1, default: 1'b0}, 1'b0);
        tc(C_MOT_OVL, '{mot_ovl: 1'b1, mot_ovl_half: 1'b1, default: 1'b0}, 1'b1);
        tc(C_MOT_OVL, '{drv_ovl: 1'b1, drv_ovl_half: 1'b1, default: 1'b0}, 1'b0);
        tc(C_STALL, '{stall_hold: 1'b1, default: 1'b0}, 1'b1);
        tc(C_READY, '{powered: 1'b1, ready: 1'b1, default: 1'b0}, 1'b1);
        tc(C_READY, '{powered: 1'b1, ready: 1'b1, protect_act: 1'b1, default: 1'b0}, 1'b0);
        tc(C_OVERHEAT, '{temp_80: 1'b1, default: 1'b0}, 1'b1);
        tc(C_OVERHEAT, '{temp_80: 1'b1, heat_trip: 1'b1, default: 1'b0}, 1'b0);
        tc(C_COAST, '{coast_mode: 1'b1, stop_cmd: 1'b1, running: 1'b1, default: 1'b0}, 1'b1);
        tc(C_COAST, '{running: 1'b1, default: 1'b0}, 1'b1);
        tc(C_COAST, '0, 1'b0);
        tc(C_COAST, '{running: 1'b1, default: 1'b0}, 1'b0);
        repeat (4) begin
            rc = 6'($urandom_range(42, 18));
            tc(rc, '1, 1'b0);
        end
        // At speed within a threshold of 50
        wr(OFS_ARRIVAL, 32'h32, 1'b0);
        ms(16'h0BB8 - 16'($urandom_range(50, 0)), 16'h0BB8, 16'h0000);
        tc(C_AT_SPEED, '{running: 1'b1, default: 1'b0}, 1'b1);
        ms(16'h0BEB, 16'h0BB8, 16'h0000);
        tc(C_AT_SPEED, '{running: 1'b1, default: 1'b0}, 1'b0);
        // Current 100 with width 10: off only below 90
        ms(16'h0000, 16'h0000, 16'($urandom_range(200, 100)));
        tc(C_CURR, '{running: 1'b1, default: 1'b0}, 1'b1);
        ms(16'h0000, 16'h0000, 16'h005B);
        tc(C_CURR, '{running: 1'b1, default: 1'b0}, 1'b1);
        ms(16'h0000, 16'h0000, 16'h0059);
        tc(C_CURR, '{running: 1'b1, default: 1'b0}, 1'b0);
        // Frequency 1000 with width 50: on above 1000, off below 500
        ms(16'h03E9, 16'h0000, 16'h0000);
        tc(C_FREQ1, '{running: 1'b1, default: 1'b0}, 1'b1);
        ms(16'h0258, 16'h0000, 16'h0000);
        tc(C_FREQ1, '{running: 1'b1, default: 1'b0}, 1'b1);
        ms(16'h01F3, 16'h0000, 16'h0000);
        tc(C_FREQ1, '{running: 1'b1, default: 1'b0}, 1'b0);
        ms(16'h03E8, 16'h0000, 16'h0000);
        tc(C_FREQ1, '{running: 1'b1, default: 1'b0}, 1'b0);
        // Interrupt: raise, mask, unmask, clear
        tc(C_FAULT, '0, 1'b0);
        wr(OFS_INT_STAT, 32'h7, 1'b0);
        wr(OFS_INT_MASK, 32'h1, 1'b0);
        rd(OFS_INT_STAT, 32'h0, 32'h7);
        flags <= '{fault: 1'b1, default: 1'b0};
        repeat (6) @(posedge pclk);
        exp_irq = 1'b1;
        rd(OFS_INT_STAT, 32'h5, 32'h7);
        wr(OFS_INT_MASK, 32'h0, 1'b0);
        exp_irq = 1'b0;
        rd(OFS_INT_MASK, 32'h0, 32'h7);
        wr(OFS_INT_MASK, 32'h1, 1'b0);
        exp_irq = 1'b1;
        wr(OFS_INT_STAT, 32'h1, 1'b0);
        exp_irq = 1'b0;
        rd(OFS_INT_STAT, 32'h4, 32'h7);
        repeat (4) @(posedge pclk);
        print_verdict();
    end
endmodule // status_output_terminal_selector_bench

//--- tb/term_load_model.sv
// Behavioural load that reads the three status terminals
module term_load_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic relay_out,
    input wire logic digital_out_one,
    input wire logic digital_out_two,
    output logic [2:0] seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // Input stage of a PLC: levels latched once per clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen <= 3'h0;
        end else begin
            seen <= {digital_out_two, digital_out_one, relay_out};
        end
    end
endmodule // term_load_model
